/* inc/rsd_pkg.sv */
package rsd_pkg;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 20;
    localparam int DEAD_UNIT_NS = 1000;
    localparam int DEAD_UNIT_CYC = (DEAD_UNIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int TRANS_NS = 10000;
    localparam int TRANS_CYC = (TRANS_NS + CLK_NS - 1) / CLK_NS;
    // ----------------------------------------
    // Device register indices (byte address = index * 4)
    // ----------------------------------------
    localparam logic [7:0] IDX_ILIM = 8'h02;
    localparam logic [7:0] IDX_C1A = 8'h03;
    localparam logic [7:0] IDX_C1B = 8'h04;
    localparam logic [7:0] IDX_C2A = 8'h05;
    localparam logic [7:0] IDX_C2B = 8'h06;
    localparam logic [7:0] IDX_C3A = 8'h07;
    localparam logic [7:0] IDX_C3B = 8'h08;
    localparam logic [7:0] IDX_DEAD = 8'h0e;
    localparam logic [7:0] IDX_OLV = 8'h18;
    localparam logic [7:0] IDX_STAT = 8'h1f;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int ILIM_LVL_W = 5;
    localparam int ILIM_EN_LSB = 5;
    localparam int CUR_W = 10;
    localparam int CUR_HI_W = 2;
    localparam int OLV_W = 4;
    localparam logic [7:0] OLV_MAX = 8'h0f;
    localparam logic [7:0] RST_ILIM = 8'h00;
    localparam logic [7:0] RST_CUR = 8'h00;
    localparam logic [7:0] RST_DEAD = 8'h01;
    localparam logic [7:0] RST_OLV = 8'h00;
    // ----------------------------------------
    // Color codes on the select pins
    // ----------------------------------------
    localparam logic [1:0] SEL_OFF = 2'h0;
    localparam logic [1:0] SEL_CH1 = 2'h1;
    localparam logic [1:0] SEL_CH2 = 2'h2;
    localparam logic [1:0] SEL_CH3 = 2'h3;
    // ----------------------------------------
    // Controller register indices and fields
    // ----------------------------------------
    localparam logic [7:0] HIDX_COLOR = 8'h00;
    localparam logic [7:0] HIDX_CTRL = 8'h01;
    localparam logic [7:0] HIDX_STAT = 8'h02;
    localparam int CTRL_ROT_BIT = 0;
    localparam int CTRL_HSP_BIT = 1;
    localparam int CTRL_PER_LSB = 8;
    localparam int STAT_REF_BIT = 2;
    localparam logic [15:0] RST_PERIOD = 16'h0010;

    typedef enum logic [0:0] {
        ST_STEADY = 1'b0,
        ST_BREAK = 1'b1
    } rsd_state_t;
endpackage

/* inc/rsd_link_if.sv */
`timescale 1ns/1ps
interface rsd_link_if;
    logic [1:0] color_select_pins; // Rotating color code
    // Strobe decoder listens
    modport dev (input color_select_pins);
    // Display controller drives
    modport ctl (output color_select_pins);
endinterface

/* rtl/rsd_strobe_dev.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
// How it works
// - Code picks one switch; 00 opens all
// - Code picks that channel's 10-bit setpoint
// - Setpoint code drives current DAC unchanged
// - Controller rotates red, green, blue, red
// - Open old switch before closing new
// - Dead time comes from dead-time register
// - Unchanged selection keeps its switch closed
// - Open-loop control during whole dead time
// - Open-loop control when all setpoints zero
// - Open-loop voltage code 3 V..18 V
// - Transient limit level from register 0x02
// - Per-switch enables pick transient limiting
// - Software sets limit 20% above regulation
// - Green must go to blue, never red
// - Software keeps setpoints at least 5%
module rsd_strobe_dev #(
    parameter int PADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    rsd_link_if.dev link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [2:0] switch_gate,
    output logic [rsd_pkg::CUR_W-1:0] current_setpoint_dac,
    output logic open_loop_en,
    output logic [rsd_pkg::OLV_W-1:0] open_loop_volt_code,
    output logic transient_limit_active,
    output logic [rsd_pkg::ILIM_LVL_W-1:0] transient_limit_level
);
    import rsd_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    generate
        if (PADDR_W < 10) begin : g_bad_addr
            $error("PADDR_W must be at least 10");
        end
    endgenerate

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    logic [7:0] ilim_ff, c1a_ff, c1b_ff, c2a_ff, c2b_ff;
    logic [7:0] c3a_ff, c3b_ff, dead_ff, olv_ff;
    logic [31:0] prdata_ff;
    logic pready_ff; // High in first access cycle
    logic pslverr_ff;
    logic [31:0] nxt_prdata;

    // Word index; bits above the map must be zero
    wire [7:0] idx = paddr[9:2];
    wire in_map = (paddr >> 10) == '0;
    wire hit_ilim = in_map && idx == IDX_ILIM;
    wire hit_c1a = in_map && idx == IDX_C1A;
    wire hit_c1b = in_map && idx == IDX_C1B;
    wire hit_c2a = in_map && idx == IDX_C2A;
    wire hit_c2b = in_map && idx == IDX_C2B;
    wire hit_c3a = in_map && idx == IDX_C3A;
    wire hit_c3b = in_map && idx == IDX_C3B;
    wire hit_dead = in_map && idx == IDX_DEAD;
    wire hit_olv = in_map && idx == IDX_OLV;
    wire hit_stat = in_map && idx == IDX_STAT;
    wire hit_any = hit_ilim | hit_c1a | hit_c1b | hit_c2a | hit_c2b
        | hit_c3a | hit_c3b | hit_dead | hit_olv | hit_stat;
    wire setup = psel && !penable;
    // Write lands only at the completing access edge
    wire wr_fire = psel && penable && pwrite && pready_ff;

    // Setpoint codes assembled from the register pairs
    wire [CUR_W-1:0] cur1 = {c1b_ff[CUR_HI_W-1:0], c1a_ff};
    wire [CUR_W-1:0] cur2 = {c2b_ff[CUR_HI_W-1:0], c2a_ff};
    wire [CUR_W-1:0] cur3 = {c3b_ff[CUR_HI_W-1:0], c3a_ff};

    rsd_state_t state_ff, nxt_state;
    logic [1:0] active_ff, nxt_active; // Code whose switch is closed
    logic [2:0] gate_ff, nxt_gate;
    logic open_loop_ff, tla_ff;
    wire [31:0] stat_word = {24'h0, active_ff, gate_ff, state_ff,
        open_loop_ff, tla_ff};

    // Read mux, captured in the setup cycle
    assign nxt_prdata = hit_ilim ? {24'h0, ilim_ff} :
        hit_c1a ? {24'h0, c1a_ff} :
        hit_c1b ? {24'h0, c1b_ff} :
        hit_c2a ? {24'h0, c2a_ff} :
        hit_c2b ? {24'h0, c2b_ff} :
        hit_c3a ? {24'h0, c3a_ff} :
        hit_c3b ? {24'h0, c3b_ff} :
        hit_dead ? {24'h0, dead_ff} :
        hit_olv ? {24'h0, olv_ff} :
        hit_stat ? stat_word : 32'h0;

    // Answer one cycle after setup; unmapped gives an error
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
            end
            pready_ff <= setup;
            pslverr_ff <= setup && !hit_any;
        end
    end

    // Register writes; status is read-only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ilim_ff <= RST_ILIM;
            c1a_ff <= RST_CUR;
            c1b_ff <= RST_CUR;
            c2a_ff <= RST_CUR;
            c2b_ff <= RST_CUR;
            c3a_ff <= RST_CUR;
            c3b_ff <= RST_CUR;
            dead_ff <= RST_DEAD;
            olv_ff <= RST_OLV;
        end else if (wr_fire) begin
            if (hit_ilim) ilim_ff <= pwdata[7:0];
            if (hit_c1a) c1a_ff <= pwdata[7:0];
            if (hit_c1b) c1b_ff <= pwdata[7:0];
            if (hit_c2a) c2a_ff <= pwdata[7:0];
            if (hit_c2b) c2b_ff <= pwdata[7:0];
            if (hit_c3a) c3a_ff <= pwdata[7:0];
            if (hit_c3b) c3b_ff <= pwdata[7:0];
            if (hit_dead) dead_ff <= pwdata[7:0];
            if (hit_olv) olv_ff <= pwdata[7:0];
        end
    end

    // ----------------------------------------
    // Strobe sequencer
    // ----------------------------------------
    logic [1:0] target_ff, nxt_target;
    logic [7:0] pre_ff, nxt_pre; // Cycles within one dead-time unit
    logic [7:0] unit_ff, nxt_unit; // Elapsed dead-time units
    logic [12:0] trans_ff, nxt_trans; // Transient window left
    logic [CUR_W-1:0] dac_ff, nxt_dac;

    wire [1:0] sel_in = link.color_select_pins;
    // One-hot switch for a code, none for 00
    wire [2:0] want_gate = (target_ff == SEL_OFF) ? 3'b000 :
        3'(3'b001 << (target_ff - 2'd1));
    // Setpoint for a code; 00 selects none
    wire [CUR_W-1:0] sp_target = (target_ff == SEL_CH1) ? cur1 :
        (target_ff == SEL_CH2) ? cur2 :
        (target_ff == SEL_CH3) ? cur3 : '0;
    wire [CUR_W-1:0] sp_active = (active_ff == SEL_CH1) ? cur1 :
        (active_ff == SEL_CH2) ? cur2 :
        (active_ff == SEL_CH3) ? cur3 : '0;
    wire all_zero = cur1 == '0 && cur2 == '0 && cur3 == '0;
    wire unit_tick = pre_ff == 8'(DEAD_UNIT_CYC - 1);
    // A zero dead-time register still leaves one open cycle
    wire dead_done = unit_ff >= dead_ff;
    wire lim_en = |(want_gate & ilim_ff[ILIM_EN_LSB +: 3]);

    // Next-state logic of the sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_active = active_ff;
        nxt_target = target_ff;
        nxt_gate = gate_ff;
        nxt_pre = '0;
        nxt_unit = '0;
        nxt_dac = dac_ff;
        nxt_trans = (trans_ff != '0) ? trans_ff - 13'd1 : '0;
        case (state_ff)
            ST_STEADY: begin
                if (sel_in == active_ff) begin
                    // Same selection: switch stays closed
                    nxt_dac = sp_active;
                end else if (sel_in == SEL_OFF) begin
                    // Nothing to make; just break
                    nxt_gate = 3'b000;
                    nxt_active = SEL_OFF;
                    nxt_dac = '0;
                end else begin
                    // Break first, make after dead time
                    nxt_gate = 3'b000;
                    nxt_active = SEL_OFF;
                    nxt_target = sel_in;
                    nxt_dac = '0;
                    nxt_state = ST_BREAK;
                end
            end
            ST_BREAK: begin
                if (sel_in == SEL_OFF) begin
                    // Code dropped to off mid-gap: abort
                    nxt_target = SEL_OFF;
                    nxt_state = ST_STEADY;
                end else if (sel_in != target_ff) begin
                    // Retarget, keep the elapsed gap
                    nxt_target = sel_in;
                    nxt_pre = pre_ff;
                    nxt_unit = unit_ff;
                end else if (dead_done) begin
                    // Make the new switch and load its setpoint
                    nxt_gate = want_gate;
                    nxt_active = target_ff;
                    nxt_dac = sp_target;
                    nxt_state = ST_STEADY;
                    if (lim_en) begin
                        nxt_trans = 13'(TRANS_CYC);
                    end
                end else begin
                    // Count the programmed dead time
                    nxt_pre = unit_tick ? 8'h0 : pre_ff + 8'h1;
                    nxt_unit = unit_tick ? unit_ff + 8'h1 : unit_ff;
                end
            end
            default: begin
                nxt_state = ST_STEADY;
            end
        endcase
    end

    // Sequencer state and registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_STEADY;
            active_ff <= SEL_OFF;
            target_ff <= SEL_OFF;
            gate_ff <= 3'b000;
            pre_ff <= 8'h0;
            unit_ff <= 8'h0;
            trans_ff <= 13'h0;
            dac_ff <= '0;
            open_loop_ff <= 1'b1;
            tla_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            active_ff <= nxt_active;
            target_ff <= nxt_target;
            gate_ff <= nxt_gate;
            pre_ff <= nxt_pre;
            unit_ff <= nxt_unit;
            trans_ff <= nxt_trans;
            dac_ff <= nxt_dac;
            // No LED path: gap, all setpoints zero, or code 00
            open_loop_ff <= nxt_state == ST_BREAK
                || all_zero
                || nxt_active == SEL_OFF;
            tla_ff <= nxt_trans != '0;
        end
    end

    // Analog-facing settings, registered to keep outputs glitch free
    logic [OLV_W-1:0] olv_code_ff;
    logic [ILIM_LVL_W-1:0] ilim_lvl_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            olv_code_ff <= '0;
            ilim_lvl_ff <= '0;
        end else begin
            // Codes above 18 V clamp to 18 V
            olv_code_ff <= (olv_ff > OLV_MAX) ? OLV_W'(OLV_MAX)
                : olv_ff[OLV_W-1:0];
            ilim_lvl_ff <= ilim_ff[ILIM_LVL_W-1:0];
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign switch_gate = gate_ff;
    assign current_setpoint_dac = dac_ff;
    assign open_loop_en = open_loop_ff;
    assign open_loop_volt_code = olv_code_ff;
    assign transient_limit_active = tla_ff;
    assign transient_limit_level = ilim_lvl_ff;
endmodule

/* rtl/rsd_strobe_ctl.sv */
`timescale 1ns/1ps
module rsd_strobe_ctl #(
    parameter int PADDR_W = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    rsd_link_if.ctl link,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    import rsd_pkg::*;

    generate
        if (PADDR_W < 10) begin : g_bad_addr
            $error("PADDR_W must be at least 10");
        end
    endgenerate

    // ----------------------------------------
    // Register bus slave
    // ----------------------------------------
    logic [1:0] pins_ff; // Code on the select pins
    logic rot_ff, hsp_ff, refused_ff;
    logic [15:0] period_ff; // Rotation step minus one, in dead-time units
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff;

    wire [7:0] idx = paddr[9:2];
    wire in_map = (paddr >> 10) == '0;
    wire hit_color = in_map && idx == HIDX_COLOR;
    wire hit_ctrl = in_map && idx == HIDX_CTRL;
    wire hit_stat = in_map && idx == HIDX_STAT;
    wire setup = psel && !penable;
    wire wr_fire = psel && penable && pwrite && pready_ff;
    wire [31:0] ctrl_word = {8'h0, period_ff, 6'h0, hsp_ff, rot_ff};
    wire [31:0] stat_word = {29'h0, refused_ff, pins_ff};
    wire [31:0] nxt_prdata = hit_color ? {30'h0, pins_ff} :
        hit_ctrl ? ctrl_word :
        hit_stat ? stat_word : 32'h0;

    // Answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            if (setup) begin
                prdata_ff <= pwrite ? 32'h0 : nxt_prdata;
            end
            pready_ff <= setup;
            pslverr_ff <= setup && !(hit_color | hit_ctrl | hit_stat);
        end
    end

    // ----------------------------------------
    // Color code generation
    // ----------------------------------------
    logic [7:0] pre_ff;
    logic [15:0] step_ff;
    wire unit_tick = pre_ff == 8'(DEAD_UNIT_CYC - 1);
    wire step_due = rot_ff && unit_tick && step_ff >= period_ff;
    // Red, green, blue, red; off starts at red
    wire [1:0] rot_next = (pins_ff == SEL_CH3 || pins_ff == SEL_OFF)
        ? SEL_CH1 : pins_ff + 2'd1;
    wire color_wr = wr_fire && hit_color && !rot_ff;
    // Green straight to red would harm a stacked green
    wire bad_step = hsp_ff && pins_ff == SEL_CH2
        && pwdata[1:0] == SEL_CH1;
    wire clr_ref = wr_fire && hit_stat && pwdata[STAT_REF_BIT];

    // Control register writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rot_ff <= 1'b0;
            hsp_ff <= 1'b0;
            period_ff <= RST_PERIOD;
        end else if (wr_fire && hit_ctrl) begin
            rot_ff <= pwdata[CTRL_ROT_BIT];
            hsp_ff <= pwdata[CTRL_HSP_BIT];
            period_ff <= pwdata[CTRL_PER_LSB +: 16];
        end
    end

    // Pin code, rotation timer and refusal flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_ff <= SEL_OFF;
            pre_ff <= 8'h0;
            step_ff <= 16'h0;
            refused_ff <= 1'b0;
        end else begin
            pre_ff <= (unit_tick || !rot_ff) ? 8'h0 : pre_ff + 8'h1;
            if (!rot_ff || step_due) begin
                step_ff <= 16'h0;
            end else if (unit_tick) begin
                step_ff <= step_ff + 16'h1;
            end
            if (step_due) begin
                pins_ff <= rot_next;
            end else if (color_wr && !bad_step) begin
                pins_ff <= pwdata[1:0];
            end
            // A new refusal wins over a clear in the same cycle
            if (color_wr && bad_step) begin
                refused_ff <= 1'b1;
            end else if (clr_ref) begin
                refused_ff <= 1'b0;
            end
        end
    end

    assign link.color_select_pins = pins_ff;
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule

/* dv/rsd_strobe_properties.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Link and switch timing checks
// ----------------------------------------
module rsd_strobe_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [1:0] color_select_pins,
    input wire logic [2:0] switch_gate,
    input wire logic [rsd_pkg::CUR_W-1:0] current_setpoint_dac,
    input wire logic open_loop_en,
    input wire logic transient_limit_active
);
    import rsd_pkg::*;
    // Gate pattern the present code asks for
    logic [2:0] dec_gate;
    assign dec_gate = (color_select_pins == SEL_OFF) ? 3'h0 :
        3'h1 << (color_select_pins - 2'h1);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Steps of a selection change
    sequence s_code_step;
        $changed(color_select_pins);
    endsequence
    sequence s_all_open;
        (switch_gate == 3'h0) && open_loop_en;
    endsequence

    property p_break;
        s_code_step |=> s_all_open;
    endproperty
    property p_onehot;
        $onehot0(switch_gate);
    endproperty
    property p_decode;
        (switch_gate != 3'h0 && $stable(color_select_pins))
            |-> switch_gate == dec_gate;
    endproperty
    // A new switch never closes straight after another one
    property p_no_overlap;
        (switch_gate != 3'h0 && $changed(switch_gate))
            |-> $past(switch_gate) == 3'h0;
    endproperty
    property p_keep;
        (switch_gate != 3'h0 && $stable(color_select_pins))
            |=> $stable(switch_gate);
    endproperty
    property p_open_loop;
        !open_loop_en |-> switch_gate != 3'h0;
    endproperty
    property p_dac_idle;
        switch_gate == 3'h0 |-> current_setpoint_dac == '0;
    endproperty
    property p_limit_start;
        $rose(transient_limit_active)
            |-> ($past(switch_gate) == 3'h0 && switch_gate != 3'h0);
    endproperty

    a_break: assert property (p_break)
        else $error("switch still closed after code change");
    a_onehot: assert property (p_onehot)
        else $error("more than one switch closed");
    a_decode: assert property (p_decode)
        else $error("closed switch does not match code");
    a_no_overlap: assert property (p_no_overlap)
        else $error("switch closed without open gap");
    a_keep: assert property (p_keep)
        else $error("switch moved with steady code");
    a_open_loop: assert property (p_open_loop)
        else $error("closed loop with no switch closed");
    a_dac_idle: assert property (p_dac_idle)
        else $error("setpoint applied with no switch closed");
    a_limit_start: assert property (p_limit_start)
        else $error("transient limit started without a close");
endmodule

/* dv/tb_rgb_strobe_decoder.sv */
`timescale 1ns/1ps
module tb_rgb_strobe_decoder;
    import rsd_pkg::*;
    // ----------------------------------------
    // Signals and model state
    // ----------------------------------------
    logic pclk, presetn, pwrite, penable, d_psel, c_psel, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, d_prdata, c_prdata, rd;
    logic d_pready, c_pready, d_pslverr, c_pslverr;
    logic [2:0] switch_gate;
    logic [CUR_W-1:0] current_setpoint_dac;
    logic open_loop_en, transient_limit_active;
    logic [OLV_W-1:0] open_loop_volt_code;
    logic [ILIM_LVL_W-1:0] transient_limit_level;
    logic [31:0] seed = 32'h0000_0047;
    int fail_count = 0;
    int tests_run = 0;
    int dreg [32]; // Device register image
    int ridx [9] = '{2, 3, 4, 5, 6, 7, 8, 14, 24};
    int rot [4] = '{1, 2, 3, 1};
    int n, i, prev;

    rsd_link_if link ();
    rsd_strobe_dev #(.PADDR_W(12)) rsd_strobe_dev_i (.pclk(pclk),
        .presetn(presetn), .link(link), .psel(d_psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(d_prdata),
        .pready(d_pready), .pslverr(d_pslverr), .switch_gate(switch_gate),
        .current_setpoint_dac(current_setpoint_dac),
        .open_loop_en(open_loop_en),
        .open_loop_volt_code(open_loop_volt_code),
        .transient_limit_active(transient_limit_active),
        .transient_limit_level(transient_limit_level));
    rsd_strobe_ctl #(.PADDR_W(12)) rsd_strobe_ctl_i (.pclk(pclk),
        .presetn(presetn), .link(link), .psel(c_psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(c_prdata),
        .pready(c_pready), .pslverr(c_pslverr));
    rsd_strobe_properties rsd_strobe_properties_i (.pclk(pclk),
        .presetn(presetn), .color_select_pins(link.color_select_pins),
        .switch_gate(switch_gate),
        .current_setpoint_dac(current_setpoint_dac),
        .open_loop_en(open_loop_en),
        .transient_limit_active(transient_limit_active));

    // 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Expected setpoint of a channel, none for code 00
    function automatic int exp_dac(int c);
        if (c == 0) return 0;
        return (dreg[2 * c + 2] & 3) * 256 + dreg[2 * c + 1];
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // One APB transfer; shared bus, one select per slave
    task automatic apb(input bit dev, input bit wr, input logic [7:0] idx,
        input logic [31:0] wd);
        @(posedge pclk);
        paddr <= {2'h0, idx, 2'h0};
        pwrite <= wr;
        pwdata <= wd;
        d_psel <= dev;
        c_psel <= !dev;
        @(posedge pclk);
        penable <= 1'b1;
        // Wait for the answer; only the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while ((dev ? d_pready : c_pready) !== 1'b1);
        rd = dev ? d_prdata : c_prdata;
        err = dev ? d_pslverr : c_pslverr;
        d_psel <= 1'b0;
        c_psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wdev(input logic [7:0] idx, input int v);
        apb(1'b1, 1'b1, idx, v);
        dreg[idx] = v;
    endtask
    task automatic rchk(input bit dev, input logic [7:0] idx,
        input logic [31:0] exp, input logic eerr);
        apb(dev, 1'b0, idx, 32'h0);
        check(rd, exp);
        check(err, eerr);
    endtask
    // Select a code and time the gap up to the close
    task automatic sel(input int c);
        logic [2:0] g;
        g = (c == 0) ? 3'h0 : 3'h1 << (c - 1);
        apb(1'b0, 1'b1, HIDX_COLOR, c);
        n = 0;
        do begin
            @(posedge pclk);
            #1;
            n++;
        end while (link.color_select_pins !== c[1:0] && n < 8);
        check(link.color_select_pins, c[1:0]);
        n = 0;
        while (switch_gate !== g && n < 13000) begin
            @(posedge pclk);
            #1;
            n++;
        end
        check(n, (c == 0) ? 0 : dreg[14] * DEAD_UNIT_CYC + 1);
        check(current_setpoint_dac, exp_dac(c));
        check(open_loop_en, c == 0 ||
            exp_dac(1) + exp_dac(2) + exp_dac(3) == 0);
        check(transient_limit_active, c != 0 &&
            ((dreg[2] >> (4 + c)) & 1));
        n = 0;
        while (transient_limit_active === 1'b1 && n < 600) begin
            @(posedge pclk);
            #1;
            n++;
        end
        if (c != 0 && ((dreg[2] >> (4 + c)) & 1))
            check(n, TRANS_CYC);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        presetn = 1'b0;
        {pwrite, penable, d_psel, c_psel, paddr, pwdata} = '0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        check(switch_gate, 3'h0);
        check(open_loop_en, 1'b1);
        check(current_setpoint_dac, 0);
        // Reset values, then the refused places on both sides
        foreach (ridx[j]) begin
            dreg[ridx[j]] = (ridx[j] == 14) ? RST_DEAD : (ridx[j] == 24) ?
                RST_OLV : (ridx[j] == 2) ? RST_ILIM : RST_CUR;
            rchk(1'b1, ridx[j], dreg[ridx[j]], 1'b0);
        end
        rchk(1'b1, 8'h40, 32'h0, 1'b1);
        rchk(1'b0, 8'h10, 32'h0, 1'b1);
        // Limit on the first switch only, at the top level
        wdev(IDX_ILIM, 8'h20 | 31);
        for (i = 3; i <= 8; i++)
            wdev(i, (i % 2) ? (xorshift() & 255) | 64 : xorshift() & 3);
        wdev(IDX_OLV, xorshift() & 15);
        foreach (ridx[j]) rchk(1'b1, ridx[j], dreg[ridx[j]], 1'b0);
        check(open_loop_volt_code, dreg[24]);
        check(transient_limit_level, dreg[2] & 31);
        foreach (rot[j]) sel(rot[j]);
        wdev(IDX_DEAD, 0);
        sel(2);
        wdev(IDX_DEAD, 2);
        sel(3);
        sel(0);
        sel(1);
        // Same code again leaves the switch closed
        apb(1'b0, 1'b1, HIDX_COLOR, 1);
        n = 0;
        repeat (60) begin
            @(posedge pclk);
            #1;
            if (switch_gate !== 3'h1) n++;
        end
        check(n, 0);
        rchk(1'b1, IDX_STAT, 32'h48, 1'b0);
        for (i = 3; i <= 8; i++) wdev(i, 0);
        repeat (2) @(posedge pclk);
        #1;
        check(open_loop_en, 1'b1);
        check(current_setpoint_dac, 0);
        sel(2);
        // Stacked-green guard refuses green to red
        apb(1'b0, 1'b1, HIDX_CTRL, 32'h2);
        apb(1'b0, 1'b1, HIDX_COLOR, 1);
        repeat (4) @(posedge pclk);
        #1;
        check(link.color_select_pins, 2'h2);
        rchk(1'b0, HIDX_STAT, 32'h6, 1'b0);
        apb(1'b0, 1'b1, HIDX_STAT, 32'h4);
        rchk(1'b0, HIDX_STAT, 32'h2, 1'b0);
        // Free rotation, one step every two dead-time units
        wdev(IDX_DEAD, 0);
        sel(0);
        apb(1'b0, 1'b1, HIDX_CTRL, 32'h0000_0101);
        prev = 0;
        foreach (rot[j]) begin
            n = 0;
            while (link.color_select_pins === prev[1:0] && n < 400) begin
                @(posedge pclk);
                #1;
                n++;
            end
            check(link.color_select_pins, rot[j]);
            if (j > 0) check(n, 2 * DEAD_UNIT_CYC);
            prev = rot[j];
        end
        apb(1'b0, 1'b1, HIDX_CTRL, 32'h0);
        summarize();
    end
    // Whole run is a few thousand cycles; far past that is a hang
    initial begin
        #400000;
        fail_count++;
        summarize();
    end
endmodule
